// ### chgsm_top.v
`include "chgsm_map.vh"

// Notes on behaviour
// - Main input above 7.5V: line power present, charging allowed, bit 15.
// - Main below cell plus 0.3V: power fail, source switch off, bit 13.
// - Thermistor below 91% of supply: battery present, bit 14, may charge.
// - Without a battery every command register stays at its reset value.
// - Without a battery command float charge, 18.32V at 128mA compliance.
// - Cell below 2.5V caps current at 128mA; released above 2.7V.
// - Voltage setpoint kept in undervoltage; accepted down to 1.024V.
// - Logic supply below 2.5V: ignore bus commands and do not charge.
// - Leaving logic undervoltage starts from power-on reset defaults.
// - Slave only; never starts transfers, just takes commands and answers.
// - All exchanges use read-word and write-word formats.
// - Respond only to address 0x12 and decode supported commands.
// - Read-word of 0x11 returns fixed specification version word.
// - Write-word of 0x12 loads mode word, D0 to mode bit 0.
// - Word bit 0 is LSB of the low byte, which is sent first.
// - Overtemperature halt bit powers up as 1, returns to 1 on removal.
// - Mode bit 0 sets or clears halt latch; otherwise only reset or removal clears it.
// - Mode bit 2 loads setpoints 0xFFFF and 0x00C0, clears thermal, alarm.
// - Mode bit 4 low: interrupt on either edge of line power flag.
module chgsm_top #(
  parameter [15:0] SPEC_WORD = 16'h0005 // Arbitrary value
) (
  input wire clk,
  input wire resetn,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out_r,
  output reg sda_oe_r,
  output reg int_out_r,
  output reg int_oe_r,
  input wire [`CHGSM_CMP_W-1:0] cmp_in,
  output reg source_switch_drive_r,
  output reg charge_on_r,
  output reg float_charge_r,
  output reg cur_cap_r,
  output reg [15:0] voltage_setpoint_r,
  output reg [15:0] current_setpoint_r
);
  localparam S_IDLE = 3'd0;
  localparam S_RX = 3'd1;
  localparam S_ACK = 3'd2;
  localparam S_TX = 3'd3;
  localparam S_MACK = 3'd4;

  reg [`CHGSM_CMP_W-1:0] cmp_m_r, cmp_s_r;
  reg scl_m_r, scl_s_r, scl_d_r;
  reg sda_m_r, sda_s_r, sda_d_r;
  reg [2:0] st_r;
  reg [3:0] bit_r;
  reg [7:0] sh_r;
  reg [1:0] phase_r;
  reg [7:0] cmd_r;
  reg [7:0] dlo_r;
  reg rd_r;
  reg txhi_r;
  reg [15:0] tx_r;
  reg halt_latch_r;
  reg overtemp_halt_r;
  reg line_change_irq_mask_r;
  reg thermal_high_latch_r;
  reg alarm_latch_r;
  reg line_d_r;

  // Synchronised comparator and bus levels
  wire line_power_ok = cmp_s_r[`CHGSM_CMP_LINE];
  wire power_fail = cmp_s_r[`CHGSM_CMP_PFAIL];
  wire cell_voltage_pin_present = cmp_s_r[`CHGSM_CMP_CELL_VOLTAGE_PIN];
  wire cell_below_lo = cmp_s_r[`CHGSM_CMP_UV_LO];
  wire cell_above_hi = cmp_s_r[`CHGSM_CMP_UV_HI];
  wire vdd_uv = cmp_s_r[`CHGSM_CMP_VDD_UV];
  wire therm_hot = cmp_s_r[`CHGSM_CMP_THERM];
  wire alarm_evt = cmp_s_r[`CHGSM_CMP_ALARM];

  wire scl_rise = scl_s_r & ~scl_d_r;
  wire scl_fall = ~scl_s_r & scl_d_r;
  wire start_det = scl_s_r & scl_d_r & ~sda_s_r & sda_d_r;
  wire stop_det = scl_s_r & scl_d_r & sda_s_r & ~sda_d_r;
  // Logic undervoltage behaves as a held reset
  wire clr = ~resetn | vdd_uv;

  wire [15:0] status_word = {line_power_ok, cell_voltage_pin_present, power_fail, 1'b0,
    thermal_high_latch_r, alarm_latch_r, 8'h00,
    overtemp_halt_r, halt_latch_r};
  wire cmd_readable = (cmd_r == `CHGSM_CMD_SPEC) ||
    (cmd_r == `CHGSM_CMD_STATUS);
  wire [7:0] tx_byte = txhi_r ? tx_r[15:8] : tx_r[7:0];
  wire [15:0] mode_word = {sh_r, dlo_r};
  wire mode_wr = scl_fall && (st_r == S_RX) && (bit_r == 4'd8) &&
    (phase_r == 2'd3) && !rd_r && (cmd_r == `CHGSM_CMD_MODE);
  wire por_wr = mode_wr && mode_word[`CHGSM_MODE_POR];
  wire status_rd = scl_fall && (st_r == S_ACK) && rd_r &&
    (cmd_r == `CHGSM_CMD_STATUS);

  // Two stages on every asynchronous level
  always @(posedge clk) begin
    // Open drain: the data pin is only ever pulled low
    sda_out_r <= 1'b0;
    if (!resetn) begin
      cmp_m_r <= {`CHGSM_CMP_W{1'b0}};
      cmp_s_r <= {`CHGSM_CMP_W{1'b0}};
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      cmp_m_r <= cmp_in;
      cmp_s_r <= cmp_m_r;
      scl_m_r <= scl_in;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end

  // Slave engine; SDA only ever pulled low, never a START of its own
  always @(posedge clk) begin
    if (clr) begin
      st_r <= S_IDLE;
      bit_r <= 4'd0;
      sh_r <= 8'h00;
      phase_r <= 2'd0;
      cmd_r <= 8'h00;
      dlo_r <= 8'h00;
      rd_r <= 1'b0;
      txhi_r <= 1'b0;
      tx_r <= 16'h0000;
      sda_oe_r <= 1'b0;
    end else if (start_det) begin
      st_r <= S_RX;
      bit_r <= 4'd0;
      phase_r <= 2'd0;
      rd_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (stop_det) begin
      st_r <= S_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      case (st_r)
        S_IDLE: begin
          sda_oe_r <= 1'b0;
        end
        S_RX: begin
          if (scl_rise && bit_r != 4'd8) begin
            sh_r <= {sh_r[6:0], sda_s_r};
            bit_r <= bit_r + 4'd1;
          end else if (scl_fall && bit_r == 4'd8) begin
            bit_r <= 4'd0;
            st_r <= S_ACK;
            case (phase_r)
              2'd0: begin
                if ({sh_r[7:1], 1'b0} == `CHGSM_SLAVE_ADDR) begin
                  rd_r <= sh_r[0];
                  // Read only after a readable command was latched
                  sda_oe_r <= ~sh_r[0] | cmd_readable;
                  if (sh_r[0] && !cmd_readable)
                    st_r <= S_IDLE;
                  if (sh_r[0] && cmd_r == `CHGSM_CMD_SPEC)
                    tx_r <= SPEC_WORD;
                  else
                    tx_r <= status_word;
                  txhi_r <= 1'b0;
                end else begin
                  st_r <= S_IDLE;
                end
              end
              2'd1: begin
                cmd_r <= sh_r;
                if (sh_r == `CHGSM_CMD_SPEC || sh_r == `CHGSM_CMD_MODE ||
                    sh_r == `CHGSM_CMD_STATUS) begin
                  sda_oe_r <= 1'b1;
                end else begin
                  sda_oe_r <= 1'b0;
                  st_r <= S_IDLE;
                end
              end
              default: begin
                dlo_r <= sh_r;
                // Data bytes only for the writable command
                if (cmd_r == `CHGSM_CMD_MODE) begin
                  sda_oe_r <= 1'b1;
                end else begin
                  sda_oe_r <= 1'b0;
                  st_r <= S_IDLE;
                end
              end
            endcase
            phase_r <= (phase_r == 2'd3) ? 2'd3 : phase_r + 2'd1;
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            if (rd_r) begin
              sda_oe_r <= ~tx_byte[7];
              bit_r <= 4'd1;
              st_r <= S_TX;
            end else begin
              sda_oe_r <= 1'b0;
              st_r <= S_RX;
            end
          end
        end
        S_TX: begin
          if (scl_fall) begin
            if (bit_r == 4'd8) begin
              sda_oe_r <= 1'b0;
              bit_r <= 4'd0;
              st_r <= S_MACK;
            end else begin
              sda_oe_r <= ~tx_byte[3'd7 - bit_r[2:0]];
              bit_r <= bit_r + 4'd1;
            end
          end
        end
        S_MACK: begin
          if (scl_rise) begin
            // Master NACK or second byte done ends the word
            if (sda_s_r || txhi_r)
              st_r <= S_IDLE;
            else
              txhi_r <= 1'b1;
          end else if (scl_fall && txhi_r) begin
            sda_oe_r <= ~tx_r[15];
            bit_r <= 4'd1;
            st_r <= S_TX;
          end
        end
        default: begin
          st_r <= S_IDLE;
        end
      endcase
    end
  end

  // Command registers and latches
  always @(posedge clk) begin
    if (clr || !cell_voltage_pin_present) begin
      halt_latch_r <= 1'b0;
      overtemp_halt_r <= 1'b1;
      line_change_irq_mask_r <= 1'b0;
      thermal_high_latch_r <= 1'b0;
      alarm_latch_r <= 1'b0;
      voltage_setpoint_r <= `CHGSM_VSET_RESET;
      current_setpoint_r <= `CHGSM_ISET_RESET;
    end else begin
      if (mode_wr) begin
        halt_latch_r <= mode_word[`CHGSM_MODE_HALT];
        line_change_irq_mask_r <= mode_word[`CHGSM_MODE_IRQ_MASK];
        overtemp_halt_r <= mode_word[`CHGSM_MODE_OT_HALT];
      end
      if (por_wr) begin
        voltage_setpoint_r <= `CHGSM_VSET_POR;
        current_setpoint_r <= `CHGSM_ISET_POR;
      end
      // An event in the clearing cycle still lands
      thermal_high_latch_r <= therm_hot | (thermal_high_latch_r & ~por_wr);
      alarm_latch_r <= alarm_evt | (alarm_latch_r & ~por_wr);
    end
  end

  // Power path and interrupt
  always @(posedge clk) begin
    if (clr) begin
      source_switch_drive_r <= 1'b0;
      charge_on_r <= 1'b0;
      float_charge_r <= 1'b0;
      cur_cap_r <= 1'b1;
      line_d_r <= 1'b0;
      int_oe_r <= 1'b0;
      int_out_r <= 1'b0;
    end else begin
      source_switch_drive_r <= line_power_ok & ~power_fail;
      float_charge_r <= ~cell_voltage_pin_present;
      // With a battery, setpoints below the minimum stop charging
      charge_on_r <= line_power_ok & ~power_fail & ~halt_latch_r &
        ~(overtemp_halt_r & thermal_high_latch_r) &
        (~cell_voltage_pin_present |
        ((voltage_setpoint_r >= `CHGSM_VSET_MIN) &
        (current_setpoint_r >= `CHGSM_ISET_MIN)));
      // Hysteresis band keeps the cap from chattering
      if (!cell_voltage_pin_present || cell_below_lo)
        cur_cap_r <= 1'b1;
      else if (cell_above_hi)
        cur_cap_r <= 1'b0;
      line_d_r <= line_power_ok;
      // Pending until a status read or mask bit set; an unmasked edge wins over the read clear
      if ((line_power_ok ^ line_d_r) && !line_change_irq_mask_r)
        int_oe_r <= 1'b1;
      else if (status_rd || line_change_irq_mask_r)
        int_oe_r <= 1'b0;
    end
  end

endmodule // chgsm_top

// ### chgsm_map.vh
`ifndef CHGSM_MAP_VH
`define CHGSM_MAP_VH
// Bus address, 8-bit form with direction bit clear
`define CHGSM_SLAVE_ADDR 8'h12
// Command codes
`define CHGSM_CMD_SPEC 8'h11
`define CHGSM_CMD_MODE 8'h12
`define CHGSM_CMD_STATUS 8'h13
// Mode word bit positions
`define CHGSM_MODE_HALT 0
`define CHGSM_MODE_POR 2
`define CHGSM_MODE_IRQ_MASK 4
`define CHGSM_MODE_OT_HALT 5
// Status word bit positions
`define CHGSM_ST_HALT 0
`define CHGSM_ST_OT_HALT 1
`define CHGSM_ST_ALARM 10
`define CHGSM_ST_THERM_HIGH 11
`define CHGSM_ST_PFAIL 13
`define CHGSM_ST_CELL_VOLTAGE_PIN 14
`define CHGSM_ST_LINE 15
// Setpoint values
`define CHGSM_VSET_RESET 16'h0000
`define CHGSM_ISET_RESET 16'h0000
`define CHGSM_VSET_POR 16'hffff
`define CHGSM_ISET_POR 16'h00c0
`define CHGSM_VSET_MIN 16'h0400
`define CHGSM_ISET_MIN 16'h0080
// Comparator input bit positions
`define CHGSM_CMP_LINE 0
`define CHGSM_CMP_PFAIL 1
`define CHGSM_CMP_CELL_VOLTAGE_PIN 2
`define CHGSM_CMP_UV_LO 3
`define CHGSM_CMP_UV_HI 4
`define CHGSM_CMP_VDD_UV 5
`define CHGSM_CMP_THERM 6
`define CHGSM_CMP_ALARM 7
`define CHGSM_CMP_W 8
`endif

// ### chgsm_assertions.sv
module chgsm_assertions (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_out_r,
  input wire logic sda_oe_r,
  input wire logic int_out_r,
  input wire logic int_oe_r,
  input wire logic [7:0] cmp_in,
  input wire logic source_switch_drive_r,
  input wire logic charge_on_r,
  input wire logic float_charge_r,
  input wire logic cur_cap_r,
  input wire logic [15:0] voltage_setpoint_r,
  input wire logic [15:0] current_setpoint_r
);
  timeunit 1ns;
  timeprecision 1ps;
  // Edge checks wait out the resync that follows any reset
  logic [3:0] quiet_r;
  wire settled = (quiet_r == 4'hf);
  always_ff @(posedge clk) begin
    if (!resetn || cmp_in[5])
      quiet_r <= 4'h0;
    else if (!settled)
      quiet_r <= quiet_r + 4'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  slave_only_a:
    assert property ($changed(sda_oe_r) |-> !scl_in)
    else $error("sda moved while scl high");
  open_drain_a:
    assert property (!sda_out_r && !int_out_r)
    else $error("open drain output driven high");
  reset_state_a:
    assert property (disable iff (1'b0) !resetn |=> !sda_oe_r &&
      !charge_on_r && cur_cap_r && voltage_setpoint_r == 16'h0000)
    else $error("reset state wrong");
  line_ok_a:
    assert property ((settled && cmp_in[0] && !cmp_in[1]) [*4] |=>
      source_switch_drive_r)
    else $error("source switch off with line ok");
  pfail_off_a:
    assert property (cmp_in[1] [*4] |=> !source_switch_drive_r)
    else $error("source switch on in power fail");
  no_cell_voltage_pin_a:
    assert property ((settled && !cmp_in[2]) [*4] |=> float_charge_r &&
      voltage_setpoint_r == 16'h0000 && current_setpoint_r == 16'h0000)
    else $error("no battery state wrong");
  vdd_low_a:
    assert property (cmp_in[5] [*4] |=> !charge_on_r && !sda_oe_r)
    else $error("active during logic undervoltage");
  cell_low_a:
    assert property (cmp_in[3] [*4] |=> cur_cap_r)
    else $error("current not capped");
  cap_keep_a:
    assert property ($rose(cur_cap_r) && !float_charge_r && settled |->
      $stable(voltage_setpoint_r) && $stable(current_setpoint_r))
    else $error("setpoint changed by cap");
  line_irq_a:
    assert property ($rose(int_oe_r) && settled |->
      $past(cmp_in[0], 2) != $past(cmp_in[0], 5))
    else $error("interrupt without line change");
  cover property ($rose(charge_on_r));
  cover property ($rose(int_oe_r));
  cover property ($fell(source_switch_drive_r));
endmodule // chgsm_assertions

bind chgsm_top chgsm_assertions u_chk (.clk, .resetn, .scl_in, .sda_out_r,
  .sda_oe_r, .int_out_r, .int_oe_r, .cmp_in, .source_switch_drive_r,
  .charge_on_r, .float_charge_r, .cur_cap_r, .voltage_setpoint_r,
  .current_setpoint_r);

// ### chgsm_smb_master.sv
module chgsm_smb_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // 8 clk per bit gives 320 ns, SCL low for 4 clk
  task automatic bx(input logic b, output logic r);
    tk(2);
    sda_pull <= ~b;
    tk(2);
    scl <= 1'b1;
    tk(2);
    r = sda;
    tk(2);
    scl <= 1'b0;
  endtask
  task automatic cond(input logic st);
    tk(2);
    sda_pull <= ~st;
    tk(2);
    scl <= 1'b1;
    tk(2);
    sda_pull <= st;
    if (st) begin
      tk(2);
      scl <= 1'b0;
    end
  endtask
  task automatic wb(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--)
      bx(d[i], r);
    bx(1'b1, r);
    a = ~r;
  endtask
  task automatic rb(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bx(1'b1, r);
      d[i] = r;
    end
    bx(nack, r);
  endtask
  task automatic ww(input logic [7:0] ad, cmd, input logic [15:0] w,
    output logic [3:0] ak);
    cond(1'b1);
    wb(ad, ak[3]);
    wb(cmd, ak[2]);
    wb(w[7:0], ak[1]);
    wb(w[15:8], ak[0]);
    cond(1'b0);
  endtask
  task automatic rw(input logic [7:0] cmd, output logic [15:0] w,
    output logic [2:0] ak);
    cond(1'b1);
    wb(8'h12, ak[2]);
    wb(cmd, ak[1]);
    cond(1'b1);
    wb(8'h13, ak[0]);
    rb(1'b0, w[7:0]);
    rb(1'b1, w[15:8]);
    cond(1'b0);
  endtask
endmodule // chgsm_smb_master

// ### tb_charger_smbus_command_state.sv
module tb_charger_smbus_command_state;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] SPEC = 16'h1e2d; // Arbitrary value
  logic clk, resetn;
  logic [7:0] cmp;
  logic [15:0] w;
  logic [3:0] ak;
  wire scl, pull, sda_oe, int_oe, sda_o, int_o, src, chg, flt, cap;
  wire [15:0] vset, iset;
  wire sda = ~(pull | sda_oe);
  int fail_count = 0;
  int total_checks = 0;
  chgsm_top #(.SPEC_WORD(SPEC)) u_dut (.clk(clk), .resetn(resetn),
    .scl_in(scl), .sda_in(sda), .sda_out_r(sda_o), .sda_oe_r(sda_oe),
    .int_out_r(int_o), .int_oe_r(int_oe), .cmp_in(cmp),
    .source_switch_drive_r(src), .charge_on_r(chg), .float_charge_r(flt),
    .cur_cap_r(cap), .voltage_setpoint_r(vset), .current_setpoint_r(iset));
  chgsm_smb_master u_mst (.clk(clk), .sda(sda), .scl(scl), .sda_pull(pull));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic setc(input logic [7:0] v);
    @(posedge clk);
    cmp <= v;
    repeat (6) @(posedge clk);
  endtask
  task automatic mode(input logic [15:0] v);
    u_mst.ww(8'h12, 8'h12, v, ak);
  endtask
  task automatic stat(input logic [15:0] exp);
    u_mst.rw(8'h13, w, ak[2:0]);
    chk("status", w, exp);
  endtask
  task automatic t_idle();
    chk("float", flt, 1'b1);
    chk("vset", vset, 16'h0000);
    u_mst.rw(8'h11, w, ak[2:0]);
    chk("spec", w, SPEC);
    chk("spec ack", ak[2:0], 3'b111);
    u_mst.ww(8'h14, 8'h12, 16'h0004, ak);
    chk("bad addr", ak[3], 1'b0);
    u_mst.ww(8'h12, 8'h15, 16'h0004, ak);
    chk("bad cmd", ak[3:2], 2'b10);
    mode(16'h0004);
    chk("vset held", vset, 16'h0000);
  endtask
  task automatic t_cell_voltage_pin();
    setc(8'h15);
    chk("line irq", int_oe, 1'b1);
    chk("cap", cap, 1'b0);
    setc(8'hd5);
    setc(8'h15);
    stat(16'hcc02);
    chk("irq clr", int_oe, 1'b0);
    mode(16'h0004);
    chk("vset por", vset, 16'hffff);
    chk("iset por", iset, 16'h00c0);
    chk("chg", chg, 1'b1);
    stat(16'hc000);
    mode(16'h0001);
    chk("halt", chg, 1'b0);
    stat(16'hc001);
    mode(16'h0000);
    chk("resume", chg, 1'b1);
  endtask
  task automatic t_cell();
    setc(8'h0d);
    chk("cap low", cap, 1'b1);
    chk("iset kept", iset, 16'h00c0);
    chk("vset kept", vset, 16'hffff);
    setc(8'h05);
    chk("cap hyst", cap, 1'b1);
    setc(8'h15);
    chk("cap off", cap, 1'b0);
  endtask
  task automatic t_mask();
    mode(16'h0010);
    setc(8'h14);
    chk("masked", int_oe, 1'b0);
    setc(8'h17);
    chk("pfail src", src, 1'b0);
    stat(16'he000);
    setc(8'h11);
    chk("rm vset", vset, 16'h0000);
    chk("rm iset", iset, 16'h0000);
    chk("rm float", flt, 1'b1);
    stat(16'h8002);
  endtask
  task automatic t_vdd();
    setc(8'h35);
    mode(16'h0004);
    chk("uv ack", ak, 4'h0);
    chk("uv chg", chg, 1'b0);
    setc(8'h15);
    chk("por vset", vset, 16'h0000);
    stat(16'hc002);
  endtask
  initial begin
    resetn = 1'b0;
    cmp = 8'h00;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    t_idle();
    t_cell_voltage_pin();
    t_cell();
    t_mask();
    t_vdd();
    test_done();
  end
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    test_done();
  end
endmodule // tb_charger_smbus_command_state
